// >>> verif/alb_host_model.sv
`timescale 1ns/1ps
// processor side of the multiplexed bus, one transfer at a time
module alb_host_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] bus_in,
	input  wire logic        reply_n_in,
	output logic      [15:0] drive_n_out,
	output logic             io_sel_n_out,
	output logic             sync_n_out,
	output logic             din_n_out,
	output logic             dout_n_out,
	output logic             wtbt_n_out,
	output logic             ack_n_out
);
	// released lines float to the pull-up level, all ones
	initial begin
		drive_n_out = 16'hFFFF;
		io_sel_n_out = 1'b1;
		sync_n_out = 1'b1;
		din_n_out = 1'b1;
		dout_n_out = 1'b1;
		wtbt_n_out = 1'b1;
		ack_n_out = 1'b1;
	end

	// kind 0 write, 1 read, 2 vector; silence for 20 cycles means ignored
	task automatic xfer(input logic [15:0] addr, input logic [1:0] kind,
		input logic bw, input logic [15:0] wdata,
		output logic hit, output logic [15:0] rdata);
		int n;
		@(negedge clk_in);
		if (kind != 2'h2) begin
			drive_n_out = ~addr;
			io_sel_n_out = ~(addr[15:13] == 3'h7);
			sync_n_out = 1'b0;
			@(negedge clk_in);
			io_sel_n_out = 1'b1;
			drive_n_out = (kind == 2'h0) ? ~wdata : 16'hFFFF;
		end else begin
			ack_n_out = 1'b0;
		end
		din_n_out = (kind == 2'h0);
		dout_n_out = (kind != 2'h0);
		wtbt_n_out = ~bw;
		n = 0;
		while (reply_n_in !== 1'b0 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		hit = (reply_n_in === 1'b0);
		rdata = ~bus_in;
		din_n_out = 1'b1;
		dout_n_out = 1'b1;
		wtbt_n_out = 1'b1;
		ack_n_out = 1'b1;
		@(negedge clk_in);
		sync_n_out = 1'b1;
		drive_n_out = 16'hFFFF;
		repeat (3) @(negedge clk_in);
	endtask : xfer
endmodule : alb_host_model

// >>> verif/alb_port_test.sv
`timescale 1ns/1ps
// self-checking bench for the bus slave port
module alb_port_test;
	localparam logic [15:0] BASE = 16'hFF70;
	localparam logic [5:0]  VJ   = 6'h2D;
	logic        clk = 1'b0, srst = 1'b1, rx_req = 1'b0, tx_req = 1'b0;
	logic [15:0] drv, bus, h_out, ib_in, ib_out, rd_val = 16'h3C5A;
	logic        io_n, sync_n, din_n, dout_n, wtbt_n, ack_n, reply_n;
	logic        h_oe_n, ack_out_n, ib_oe_n, bl, bh, we, re, dir, gate, ch;
	logic [3:0]  sel;
	logic [15:0] s_ib, s_misc;
	logic        s_ack;
	int          fail_count = 0, checks_done = 0, cyc = 0;

	initial forever #2 clk = ~clk;
	// wired bus: pull-up, either party pulls low
	assign bus = drv & (h_oe_n ? 16'hFFFF : h_out);
	// register side shows inverted junk unless a read is enabled
	assign ib_in = re ? rd_val : ~rd_val;

	alb_host_model u_host (.clk_in(clk), .bus_in(bus), .reply_n_in(reply_n),
		.drive_n_out(drv), .io_sel_n_out(io_n), .sync_n_out(sync_n),
		.din_n_out(din_n), .dout_n_out(dout_n), .wtbt_n_out(wtbt_n),
		.ack_n_out(ack_n));

	alb_port u_dut (.clk_in(clk), .srst_in(srst),
		.host_addr_data_lines_n_in(bus), .host_addr_data_lines_n_out(h_out),
		.host_oe_n_out(h_oe_n), .io_page_select_n_in(io_n),
		.sync_n_in(sync_n), .din_n_in(din_n), .dout_n_in(dout_n),
		.wtbt_n_in(wtbt_n), .reply_n_out(reply_n), .ack_chain_in_n_in(ack_n),
		.ack_chain_out_n_out(ack_out_n), .rx_irq_req_in(rx_req),
		.tx_irq_req_in(tx_req), .base_address_jumpers_in(BASE[12:3]),
		.vector_jumpers_in(VJ), .internal_bus_lines_in(ib_in),
		.internal_bus_lines_out(ib_out), .internal_oe_n_out(ib_oe_n),
		.reg_sel_out(sel), .byte_low_out(bl), .byte_high_out(bh),
		.write_en_out(we), .read_en_out(re),
		.transceiver_direction_out(dir), .vector_gate_out(gate),
		.vector_choice_out(ch));

	// snapshot of the port outputs while the reply stands
	always @(negedge clk) begin
		if (reply_n === 1'b0) begin
			s_ib <= ib_out;
			s_misc <= {sel, bl, bh, we, re, dir, gate, ch, ib_oe_n, 4'h0};
		end
		if (ack_n === 1'b0)
			s_ack <= ack_out_n;
	end

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// word write then read of each of the four registers
	task automatic t_words();
		logic        hit;
		logic [15:0] d, w;
		for (int r = 0; r < 4; r++) begin
			w = 16'hA5C3 ^ 16'(r);
			u_host.xfer(BASE | 16'(r << 1), 2'h0, 1'b0, w, hit, d);
			chk("write hit", 16'(hit), 16'h0001);
			chk("write sel", 16'(s_misc[15:12]), 16'(1 << r));
			chk("write lanes", 16'(s_misc[11:9]), 16'h0007);
			chk("write oe", 16'(s_misc[4]), 16'h0000);
			chk("write data", s_ib, w);
			rd_val = 16'h3C5A ^ 16'(r << 4);
			u_host.xfer(BASE | 16'(r << 1), 2'h1, 1'b0, 16'h0000, hit, d);
			chk("read data", d, rd_val);
			chk("read sel", 16'(s_misc[15:12]), 16'(1 << r));
			chk("read dir", 16'(s_misc[8:7]), 16'h0003);
			chk("read lanes", 16'(s_misc[11:10]), 16'h0003);
			chk("read oe", 16'(s_misc[4]), 16'h0001);
			chk("idle sel", 16'(sel), 16'h0000);
			chk("idle dir", 16'(dir), 16'h0000);
		end
	endtask : t_words

	// byte writes pick one lane from address bit 0
	task automatic t_bytes();
		logic        hit;
		logic [15:0] d;
		for (int b = 0; b < 2; b++) begin
			u_host.xfer(BASE | 16'h0006 | 16'(b), 2'h0, 1'b1, 16'h1234, hit, d);
			chk("byte lanes", 16'(s_misc[11:9]), b ? 16'h0003 : 16'h0005);
		end
	endtask : t_bytes

	// wrong base bit and outside the io page are both ignored
	task automatic t_miss();
		logic        hit;
		logic [15:0] d;
		u_host.xfer(BASE ^ 16'h0008, 2'h0, 1'b0, 16'hFFFF, hit, d);
		chk("mismatch hit", 16'(hit), 16'h0000);
		u_host.xfer(BASE & 16'h1FFF, 2'h1, 1'b0, 16'h0000, hit, d);
		chk("no page hit", 16'(hit), 16'h0000);
		chk("miss dir", 16'(dir), 16'h0000);
	endtask : t_miss

	// vectors for rx, tx, both pending, then none pending
	task automatic t_vec();
		logic        hit, c;
		logic [15:0] d;
		for (int k = 1; k < 4; k++) begin
			c = (k == 2);
			@(negedge clk);
			rx_req = k[0];
			tx_req = k[1];
			u_host.xfer(16'h0000, 2'h2, 1'b0, 16'h0000, hit, d);
			chk("vector", d, (16'(VJ) << 3) | (16'(c) << 2));
			chk("gate", 16'(s_misc[6:5]), {14'h0, 1'b1, c});
		end
		@(negedge clk);
		rx_req = 1'b0;
		tx_req = 1'b0;
		u_host.xfer(16'h0000, 2'h2, 1'b0, 16'h0000, hit, d);
		chk("no request reply", 16'(hit), 16'h0000);
		chk("ack passed", 16'(s_ack), 16'h0000);
	endtask : t_vec

	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		repeat (8) @(negedge clk);
		srst = 1'b0;
		t_words();
		t_bytes();
		t_miss();
		t_vec();
		stop_test();
	end
endmodule : alb_port_test

// >>> verilog/alb_pkg.sv
// Functional notes
// - host address/data lines are inverted onto the sixteen internal bus lines.
// - device address comparison runs only while io page select is asserted.
// - without an enabled address decode, all host bus activity is ignored.
// - address bits 3 to 12 must equal base address jumpers to hit.
// - no register read or write happens without a hit this bus cycle.
// - transceivers receive by default; only transfer or interrupt logic turns them.
// - one direction signal says whether host transceivers drive or receive.
// - two vectors, receiver and transmitter; bits 3 to 8 from vector jumpers.
// - vector driven only on interrupt command; gate and choice pick which.
// - low three address bits and bus controls decode register and byte enables.
// - exactly four registers: rx status, tx status, rx buffer, tx buffer.
// - word, low byte and high byte transfers, both directions, all registers; reads here are always whole words.
// - output moves host data to internal bus; input moves internal to host.
// - status registers latch control on write and drive status on read.
// - internal bus drivers have a released state besides high and low.
// - acknowledge chain passes receiver before transmitter; receiver has priority.
// - vector is driven only after the host acknowledges a pending request.
`timescale 1ns/1ps
package alb_pkg;
	localparam int DATA_W  = 16;
	localparam int JADDR_W = 10;
	localparam int JVEC_W  = 6;
	// address field positions
	localparam int ADDR_CMP_LO  = 3;
	localparam int ADDR_CMP_HI  = 12;
	localparam int ADDR_BYTE    = 0;
	localparam int ADDR_SEL_LO  = 1;
	localparam int ADDR_SEL_HI  = 2;
	// vector field positions
	localparam int VEC_JMP_LO   = 3;
	localparam int VEC_JMP_HI   = 8;
	localparam int VEC_CHOICE   = 2;
	// register select one-hot positions, word offsets 0, 2, 4, 6
	localparam logic [1:0] REG_RX_CS  = 2'h0;
	localparam logic [1:0] REG_RX_BUF = 2'h1;
	localparam logic [1:0] REG_TX_CS  = 2'h2;
	localparam logic [1:0] REG_TX_BUF = 2'h3;
	localparam logic [3:0] SEL_NONE   = 4'h0;
	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
	localparam logic VCHOICE_RX = 1'h0;
	localparam logic VCHOICE_TX = 1'h1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_MISS,
		ST_READ,
		ST_READ_DRV,
		ST_WRITE,
		ST_VEC,
		ST_DONE
	} alb_state_t;
endpackage : alb_pkg

// builds one of the two interrupt vectors from the jumpers
module alb_vec_gen (
	input  wire logic [alb_pkg::JVEC_W-1:0] vector_jumpers_in,
	input  wire logic                       vector_choice_in,
	output logic      [alb_pkg::DATA_W-1:0] vector_out
);
	// receiver and transmitter vectors differ only in the choice bit
	always_comb begin
		vector_out = alb_pkg::ZERO_WORD;
		vector_out[alb_pkg::VEC_JMP_HI:alb_pkg::VEC_JMP_LO] =
			vector_jumpers_in;
		vector_out[alb_pkg::VEC_CHOICE] = vector_choice_in;
	end
endmodule : alb_vec_gen

// >>> verilog/alb_port.sv
`timescale 1ns/1ps
// bus slave port of the line interface card
module alb_port (
	input  wire logic                        clk_in,
	input  wire logic                        srst_in,
	input  wire logic [alb_pkg::DATA_W-1:0]  host_addr_data_lines_n_in,
	output logic      [alb_pkg::DATA_W-1:0]  host_addr_data_lines_n_out,
	output logic                             host_oe_n_out,
	input  wire logic                        io_page_select_n_in,
	input  wire logic                        sync_n_in,
	input  wire logic                        din_n_in,
	input  wire logic                        dout_n_in,
	input  wire logic                        wtbt_n_in,
	output logic                             reply_n_out,
	input  wire logic                        ack_chain_in_n_in,
	output logic                             ack_chain_out_n_out,
	input  wire logic                        rx_irq_req_in,
	input  wire logic                        tx_irq_req_in,
	input  wire logic [alb_pkg::JADDR_W-1:0] base_address_jumpers_in,
	input  wire logic [alb_pkg::JVEC_W-1:0]  vector_jumpers_in,
	input  wire logic [alb_pkg::DATA_W-1:0]  internal_bus_lines_in,
	output logic      [alb_pkg::DATA_W-1:0]  internal_bus_lines_out,
	output logic                             internal_oe_n_out,
	output logic      [3:0]                  reg_sel_out,
	output logic                             byte_low_out,
	output logic                             byte_high_out,
	output logic                             write_en_out,
	output logic                             read_en_out,
	output logic                             transceiver_direction_out,
	output logic                             vector_gate_out,
	output logic                             vector_choice_out
);
	alb_pkg::alb_state_t state;
	alb_pkg::alb_state_t next_state;
	logic [alb_pkg::DATA_W-1:0] addr_lat;
	logic                       addr_hit;
	logic [alb_pkg::DATA_W-1:0] vec_word;
	logic [alb_pkg::DATA_W-1:0] host_true;
	logic                       sync_on;
	logic                       din_on;
	logic                       dout_on;
	logic                       ack_on;
	logic                       pick_rx;
	logic                       pick_tx;
	logic                       next_choice;

	// active-low host lines carry inverted data
	assign host_true = ~host_addr_data_lines_n_in;
	assign sync_on   = ~sync_n_in;
	assign din_on    = ~din_n_in;
	assign dout_on   = ~dout_n_in;
	assign ack_on    = ~ack_chain_in_n_in;
	// receiver is offered the acknowledge first
	assign pick_rx   = rx_irq_req_in;
	assign pick_tx   = ~rx_irq_req_in & tx_irq_req_in;

	// jumpered base address compare over bits 3..12
	function automatic logic addr_match(
		input logic [alb_pkg::DATA_W-1:0]  a,
		input logic [alb_pkg::JADDR_W-1:0] j
	);
		addr_match = (a[alb_pkg::ADDR_CMP_HI:alb_pkg::ADDR_CMP_LO] == j);
	endfunction : addr_match

	// one-hot register select from address bits 2..1
	function automatic logic [3:0] reg_decode(
		input logic [alb_pkg::DATA_W-1:0] a
	);
		logic [1:0] idx;
		idx = a[alb_pkg::ADDR_SEL_HI:alb_pkg::ADDR_SEL_LO];
		reg_decode = alb_pkg::SEL_NONE;
		reg_decode[idx] = 1'h1;
	endfunction : reg_decode

	// choice the coming edge will hold; the vector word is built from it so
	// the choice bit is already right in the first driven cycle
	always_comb begin
		next_choice = vector_choice_out;
		if (state == alb_pkg::ST_IDLE && next_state == alb_pkg::ST_VEC)
			next_choice = pick_rx ? alb_pkg::VCHOICE_RX
			                      : alb_pkg::VCHOICE_TX;
	end

	alb_vec_gen u_vec (
		.vector_jumpers_in (vector_jumpers_in),
		.vector_choice_in  (next_choice),
		.vector_out        (vec_word)
	);

	// transfer sequencer; sync released ends every cycle but a vector cycle, which ends when din is released
	always_comb begin
		next_state = state;
		case (state)
			alb_pkg::ST_IDLE: begin
				if (sync_on) begin
					// decode only with io page select; else ignore bus
					if (~io_page_select_n_in &&
					    addr_match(host_true, base_address_jumpers_in))
						next_state = alb_pkg::ST_ADDR;
					else
						next_state = alb_pkg::ST_MISS;
				end else if (din_on && ack_on && (pick_rx || pick_tx)) begin
					next_state = alb_pkg::ST_VEC;
				end
			end
			alb_pkg::ST_ADDR: begin
				if (!sync_on)
					next_state = alb_pkg::ST_IDLE;
				else if (din_on)
					next_state = alb_pkg::ST_READ;
				else if (dout_on)
					next_state = alb_pkg::ST_WRITE;
			end
			alb_pkg::ST_MISS: begin
				if (!sync_on)
					next_state = alb_pkg::ST_IDLE;
			end
			alb_pkg::ST_READ: begin
				next_state = sync_on ? alb_pkg::ST_READ_DRV : alb_pkg::ST_IDLE;
			end
			alb_pkg::ST_READ_DRV: begin
				if (!sync_on)
					next_state = alb_pkg::ST_IDLE;
				else if (!din_on)
					next_state = alb_pkg::ST_DONE;
			end
			alb_pkg::ST_WRITE: begin
				if (!sync_on)
					next_state = alb_pkg::ST_IDLE;
				else if (!dout_on)
					next_state = alb_pkg::ST_DONE;
			end
			alb_pkg::ST_VEC: begin
				if (!din_on)
					next_state = alb_pkg::ST_IDLE;
			end
			alb_pkg::ST_DONE: begin
				if (!sync_on)
					next_state = alb_pkg::ST_IDLE;
			end
			default: next_state = alb_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (srst_in)
			state <= alb_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// address latch and hit flag, held for the whole bus cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			addr_lat <= alb_pkg::ZERO_WORD;
			addr_hit <= 1'h0;
		end else if (state == alb_pkg::ST_IDLE && sync_on) begin
			addr_lat <= host_true;
			addr_hit <= (next_state == alb_pkg::ST_ADDR);
		end else if (next_state == alb_pkg::ST_IDLE) begin
			addr_hit <= 1'h0;
		end
	end

	// register and byte enables; cleared the edge din, dout or sync drops
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reg_sel_out   <= alb_pkg::SEL_NONE;
			byte_low_out  <= 1'h0;
			byte_high_out <= 1'h0;
			write_en_out  <= 1'h0;
			read_en_out   <= 1'h0;
		end else if (addr_hit && (next_state == alb_pkg::ST_READ ||
		             next_state == alb_pkg::ST_READ_DRV)) begin
			reg_sel_out   <= reg_decode(addr_lat);
			byte_low_out  <= 1'h1; // reads are always whole words
			byte_high_out <= 1'h1;
			read_en_out   <= 1'h1; // status gated out on read
			write_en_out  <= 1'h0;
		end else if (addr_hit && next_state == alb_pkg::ST_WRITE) begin
			reg_sel_out   <= reg_decode(addr_lat);
			// byte write picks lane from address bit 0
			byte_low_out  <= wtbt_n_in | ~addr_lat[alb_pkg::ADDR_BYTE];
			byte_high_out <= wtbt_n_in | addr_lat[alb_pkg::ADDR_BYTE];
			write_en_out  <= 1'h1; // control latched on write
			read_en_out   <= 1'h0;
		end else begin
			reg_sel_out   <= alb_pkg::SEL_NONE;
			byte_low_out  <= 1'h0;
			byte_high_out <= 1'h0;
			write_en_out  <= 1'h0;
			read_en_out   <= 1'h0;
		end
	end

	// internal bus drive: only during a write, otherwise released
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			internal_bus_lines_out <= alb_pkg::ZERO_WORD;
			internal_oe_n_out      <= 1'h1;
		end else if (addr_hit && next_state == alb_pkg::ST_WRITE) begin
			internal_bus_lines_out <= host_true;
			internal_oe_n_out      <= 1'h0;
		end else begin
			// released so the selected register can drive it
			internal_bus_lines_out <= host_true;
			internal_oe_n_out      <= 1'h1;
		end
	end

	// host side drive: read data or a vector, else receive
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			host_addr_data_lines_n_out <= ~alb_pkg::ZERO_WORD;
			host_oe_n_out              <= 1'h1;
			transceiver_direction_out  <= 1'h0;
		end else if (next_state == alb_pkg::ST_READ_DRV) begin
			// one cycle after select so register data has settled
			host_addr_data_lines_n_out <= ~internal_bus_lines_in;
			host_oe_n_out              <= 1'h0;
			transceiver_direction_out  <= 1'h1;
		end else if (next_state == alb_pkg::ST_VEC) begin
			host_addr_data_lines_n_out <= ~vec_word;
			host_oe_n_out              <= 1'h0;
			transceiver_direction_out  <= 1'h1;
		end else begin
			host_addr_data_lines_n_out <= ~alb_pkg::ZERO_WORD;
			host_oe_n_out              <= 1'h1; // default receive
			transceiver_direction_out  <= 1'h0;
		end
	end

	// reply strobe follows the data phase
	always_ff @(posedge clk_in) begin
		if (srst_in)
			reply_n_out <= 1'h1;
		else
			reply_n_out <= ~(next_state == alb_pkg::ST_READ_DRV ||
			                 next_state == alb_pkg::ST_WRITE ||
			                 next_state == alb_pkg::ST_VEC);
	end

	// vector gate and choice; choice frozen during the vector cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			vector_gate_out   <= 1'h0;
			vector_choice_out <= alb_pkg::VCHOICE_RX;
		end else if (state == alb_pkg::ST_IDLE &&
		             next_state == alb_pkg::ST_VEC) begin
			vector_gate_out   <= 1'h1;
			vector_choice_out <= next_choice;
		end else if (next_state != alb_pkg::ST_VEC) begin
			vector_gate_out   <= 1'h0;
		end
	end

	// pass acknowledge on only when no request of ours is pending
	always_ff @(posedge clk_in) begin
		if (srst_in)
			ack_chain_out_n_out <= 1'h1;
		else if (ack_on && !rx_irq_req_in && !tx_irq_req_in &&
		         state == alb_pkg::ST_IDLE)
			ack_chain_out_n_out <= 1'h0;
		else if (!ack_on)
			ack_chain_out_n_out <= 1'h1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sel_needs_hit_a: assert property (
		(reg_sel_out != alb_pkg::SEL_NONE) |-> $past(addr_hit))
		else $error("register selected without address hit");
	hit_needs_page_a: assert property (
		$rose(addr_hit) |-> $past(~io_page_select_n_in))
		else $error("hit without io page select");
	hit_matches_a: assert property (
		$rose(addr_hit) |-> addr_lat[alb_pkg::ADDR_CMP_HI:alb_pkg::ADDR_CMP_LO]
		                    == $past(base_address_jumpers_in))
		else $error("hit on mismatched address");
	miss_ignored_a: assert property (
		state == alb_pkg::ST_MISS |=> reply_n_out && write_en_out == 1'h0)
		else $error("missed cycle was answered");
	sel_drop_a: assert property (
		(state != alb_pkg::ST_IDLE && state != alb_pkg::ST_VEC && !sync_on)
		|=> ##1 reg_sel_out == alb_pkg::SEL_NONE)
		else $error("select held after cycle end");
	dir_tie_a: assert property (
		host_oe_n_out == ~transceiver_direction_out)
		else $error("direction and host drive disagree");
	idle_receive_a: assert property (
		(state == alb_pkg::ST_IDLE && $past(state) == alb_pkg::ST_IDLE)
		|-> host_oe_n_out)
		else $error("host bus driven while idle");
	write_invert_a: assert property (
		(state == alb_pkg::ST_WRITE && next_state == alb_pkg::ST_WRITE)
		|=> internal_bus_lines_out == ~$past(host_addr_data_lines_n_in))
		else $error("internal bus not inverted host data");
	vec_after_ack_a: assert property (
		$fell(host_oe_n_out) && vector_gate_out |-> $past(ack_on && din_on))
		else $error("vector without acknowledge");
	vec_bits_a: assert property (
		vector_gate_out && !host_oe_n_out |->
		(~host_addr_data_lines_n_out) ==
		{7'h00, vector_jumpers_in, vector_choice_out, 2'h0})
		else $error("vector bits wrong");
	rx_first_a: assert property (
		(state == alb_pkg::ST_IDLE && !sync_on && din_on && ack_on &&
		 rx_irq_req_in) |=> vector_gate_out &&
		 vector_choice_out == alb_pkg::VCHOICE_RX && ack_chain_out_n_out)
		else $error("receiver priority lost");

	read_cov_c: cover property (
		state == alb_pkg::ST_READ ##1 state == alb_pkg::ST_READ_DRV);
	byte_write_c: cover property (write_en_out && !byte_high_out);
	tx_vec_c: cover property (
		vector_gate_out && vector_choice_out == alb_pkg::VCHOICE_TX);
endmodule : alb_port
